// ===== rtl/atrc_consts.svh
`ifndef ATRC_CONSTS_SVH
`define ATRC_CONSTS_SVH

// ----------------------------------------
// reference control register
// ----------------------------------------
`define ATRC_REF_CTRL_ADDR 8'hD1
`define ATRC_REF_CTRL_RESET 8'h18
`define ATRC_REF_CTRL_WMASK 8'h3D
`define ATRC_GND_BIT 5
`define ATRC_VSEL_HI 4
`define ATRC_VSEL_LO 3
`define ATRC_TEMP_BIT 2
`define ATRC_PREF_BIT 0

// ----------------------------------------
// conversion timing and width
// ----------------------------------------
`define ATRC_LP_TRACK_CLKS 2'h3
`define ATRC_RESULT_BITS 10

`endif

// ===== rtl/atrc_pkg.sv
`default_nettype none
package atrc_pkg;

	// ----------------------------------------
	// voltage reference codes
	// ----------------------------------------
	typedef enum logic [1:0] {
		ATRC_VREF_SUPPLY = 2'b00,
		ATRC_VREF_RSVD = 2'b01,
		ATRC_VREF_DIG18 = 2'b10,
		ATRC_VREF_HS165 = 2'b11
	} atrc_vref_t;

	// ----------------------------------------
	// decoded reference controls
	// ----------------------------------------
	typedef struct packed {
		logic ground_ref_select;
		atrc_vref_t voltage_ref_select;
		logic temp_sensor_enable;
		logic precision_ref_output_enable;
	} atrc_ref_t;

	// ----------------------------------------
	// track-and-hold sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		ATRC_IDLE = 2'b00,
		ATRC_TRACK = 2'b01,
		ATRC_CONV = 2'b10
	} atrc_state_t;

endpackage
`default_nettype wire

// ===== rtl/atrc_ref_reg.sv
`include "atrc_consts.svh"
`default_nettype none
module atrc_ref_reg
	import atrc_pkg::*;
(
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic ce,
	// register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	// stored value
	output logic [7:0] reg_value
);

	logic [7:0] next_reg_value;

	// ----------------------------------------
	// write with unused bits held at zero
	// ----------------------------------------
	always_comb begin
		next_reg_value = reg_value;
		if (ce && sfr_wr && sfr_addr == `ATRC_REF_CTRL_ADDR) begin
			next_reg_value = sfr_wdata & `ATRC_REF_CTRL_WMASK; // [R8]
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			reg_value <= `ATRC_REF_CTRL_RESET;
		end else begin
			reg_value <= next_reg_value;
		end
	end

endmodule
`default_nettype wire

// ===== rtl/atrc_top.sv
// Operation
// [R1] One low-power-track select input picks continuous tracking or low-power track-and-hold.
// [R2] With low-power and burst both off, the input is tracked always except during a conversion.
// [R3] In low-power mode with a software start, each conversion starts with exactly 3 converter clocks of tracking.
// [R4] In low-power mode with the pin as trigger, tracking happens only while the pin is low.
// [R5] With the pin as trigger, a conversion starts on its rising edge; the driver returns it low.
// [R6] Tracking can be shut down while the device is in standby or sleep.
// [R7] Each conversion yields a 10-bit result.
// [R8] Reference control bits 7:6 and 1 read as zero and ignore writes.
// [R9] Bit 5 selects the ground reference, zero meaning the ground pin.
// [R10] Bits 4:3 select the voltage reference: 00 supply, 10 1.8 V supply, 11 1.65 V reference.
// [R11] Bit 2 enables the temperature sensor.
// [R12] Bit 0 enables the 1.68 V precision reference and connects it to the reference pin.
// [R13] Reference code 01 is reserved and falls back to the supply reference.
`include "atrc_consts.svh"
`default_nettype none
module atrc_top
	import atrc_pkg::*;
#(
	parameter int RESULT_BITS = `ATRC_RESULT_BITS
)
(
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic ce,
	// register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// converter control bits
	input wire logic low_power_track_select,
	input wire logic burst_mode_enable,
	input wire logic ext_trigger_select,
	input wire logic sw_start,
	// convert-start pin
	input wire logic external_convert_start,
	// power state
	input wire logic low_power_state,
	input wire logic track_shutdown_enable,
	// analog converter core
	input wire logic sar_tick,
	input wire logic conv_done,
	input wire logic [RESULT_BITS-1:0] core_result,
	output logic track_en,
	output logic convert_active,
	output logic [RESULT_BITS-1:0] result,
	output logic result_valid,
	// reference controls
	output logic ground_ref_select,
	output atrc_vref_t voltage_ref_select,
	output logic temp_sensor_enable,
	output logic precision_ref_output_enable
);

	// ----------------------------------------
	// reference control register
	// ----------------------------------------
	logic [7:0] ref_value;
	atrc_ref_t ref_dec;
	atrc_ref_t ref_q;
	atrc_ref_t next_ref_q;
	logic [7:0] next_sfr_rdata;

	atrc_ref_reg u_ref_reg (
		.ref_clk(ref_clk),
		.reset(reset),
		.ce(ce),
		.sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata),
		.reg_value(ref_value)
	);

	function automatic atrc_vref_t vref_decode(input logic [1:0] code);
		atrc_vref_t sel;
		sel = atrc_vref_t'(code);
		if (sel == ATRC_VREF_RSVD) begin
			sel = ATRC_VREF_SUPPLY; // [R13]
		end
		return sel;
	endfunction

	always_comb begin
		ref_dec.ground_ref_select = ref_value[`ATRC_GND_BIT]; // [R9]
		ref_dec.voltage_ref_select = vref_decode(ref_value[`ATRC_VSEL_HI:`ATRC_VSEL_LO]); // [R10]
		ref_dec.temp_sensor_enable = ref_value[`ATRC_TEMP_BIT]; // [R11]
		ref_dec.precision_ref_output_enable = ref_value[`ATRC_PREF_BIT]; // [R12]
	end

	always_comb begin
		next_ref_q = ref_q;
		next_sfr_rdata = sfr_rdata;
		if (ce) begin
			next_ref_q = ref_dec;
			next_sfr_rdata = 8'h00;
			if (sfr_rd && sfr_addr == `ATRC_REF_CTRL_ADDR) begin
				next_sfr_rdata = ref_value; // [R8]
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ref_q <= '0;
			sfr_rdata <= 8'h00;
		end else begin
			ref_q <= next_ref_q;
			sfr_rdata <= next_sfr_rdata;
		end
	end

	assign ground_ref_select = ref_q.ground_ref_select;
	assign voltage_ref_select = ref_q.voltage_ref_select;
	assign temp_sensor_enable = ref_q.temp_sensor_enable;
	assign precision_ref_output_enable = ref_q.precision_ref_output_enable;

	// ----------------------------------------
	// start-of-conversion detection
	// ----------------------------------------
	logic pin_prev;
	logic next_pin_prev;
	logic start_evt;
	logic shutdown;

	always_comb begin
		next_pin_prev = pin_prev;
		if (ce) begin
			next_pin_prev = external_convert_start;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pin_prev <= 1'b1;
		end else begin
			pin_prev <= next_pin_prev;
		end
	end

	always_comb begin
		if (ext_trigger_select) begin
			start_evt = external_convert_start && !pin_prev; // [R5]
		end else begin
			start_evt = sw_start;
		end
		shutdown = low_power_state && track_shutdown_enable;
	end

	// ----------------------------------------
	// track-and-hold sequencer
	// ----------------------------------------
	atrc_state_t state;
	atrc_state_t next_state;
	logic [1:0] trk_cnt;
	logic [1:0] next_trk_cnt;
	logic next_track_en;
	logic next_convert_active;
	logic [RESULT_BITS-1:0] next_result;
	logic next_result_valid;

	always_comb begin
		next_state = state;
		next_trk_cnt = trk_cnt;
		next_result = result;
		next_result_valid = 1'b0;
		if (ce) begin
			unique case (state)
				ATRC_IDLE: begin
					next_trk_cnt = 2'h0;
					if (start_evt) begin
						if (low_power_track_select && !ext_trigger_select) begin // [R1]
							next_state = ATRC_TRACK; // [R3]
						end else begin
							next_state = ATRC_CONV; // [R5]
						end
					end
				end
				ATRC_TRACK: begin
					if (sar_tick) begin
						if (trk_cnt == `ATRC_LP_TRACK_CLKS - 2'h1) begin
							next_state = ATRC_CONV; // [R3]
							next_trk_cnt = 2'h0;
						end else begin
							next_trk_cnt = trk_cnt + 2'h1;
						end
					end
				end
				ATRC_CONV: begin
					if (conv_done) begin
						next_state = ATRC_IDLE;
						next_result = core_result; // [R7]
						next_result_valid = 1'b1;
					end
				end
				default: begin
					next_state = ATRC_IDLE;
					next_trk_cnt = 2'h0;
				end
			endcase
		end else begin
			next_result_valid = result_valid;
		end
	end

	// ----------------------------------------
	// tracking and convert outputs
	// ----------------------------------------
	always_comb begin
		next_track_en = track_en;
		next_convert_active = convert_active;
		if (ce) begin
			next_convert_active = (next_state == ATRC_CONV);
			unique case (next_state)
				ATRC_TRACK: begin
					next_track_en = 1'b1; // [R3]
				end
				ATRC_CONV: begin
					next_track_en = 1'b0; // [R2]
				end
				default: begin
					if (shutdown) begin
						next_track_en = 1'b0; // [R6]
					end else if (low_power_track_select && ext_trigger_select) begin
						next_track_en = !external_convert_start; // [R4]
					end else begin
						next_track_en = !low_power_track_select && !burst_mode_enable; // [R2]
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state <= ATRC_IDLE;
			trk_cnt <= 2'h0;
			track_en <= 1'b0;
			convert_active <= 1'b0;
			result <= '0;
			result_valid <= 1'b0;
		end else begin
			state <= next_state;
			trk_cnt <= next_trk_cnt;
			track_en <= next_track_en;
			convert_active <= next_convert_active;
			result <= next_result;
			result_valid <= next_result_valid;
		end
	end

endmodule
`default_nettype wire

// ===== testbench/atrc_core_model.sv
`default_nettype none
module atrc_core_model
	import atrc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// converter side
	input wire logic [1:0] div,
	input wire logic convert_active,
	output logic sar_tick,
	output logic conv_done,
	output logic [9:0] core_result
);
	logic [1:0] d;
	logic [2:0] c;
	logic [9:0] n;
	assign sar_tick = d == 2'h0;
	// inverted value outside the done pulse
	assign core_result = conv_done ? 10'h2AA + n : ~(10'h2AA + n);
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			{d, c, n, conv_done} <= '0;
		end else begin
			d <= (d >= div) ? 2'h0 : d + 2'h1;
			c <= convert_active ? c + {2'h0, sar_tick} : 3'h0;
			conv_done <= convert_active && sar_tick && c == 3'h4 && !conv_done;
			n <= n + {9'h000, conv_done};
		end
	end
endmodule
`default_nettype wire

// ===== testbench/atrc_monitor.sv
`default_nettype none
module atrc_monitor
	import atrc_pkg::*;
#(
	parameter int RESULT_BITS = 10
)
(
	// clock, reset, register port
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	// conversion control
	input wire logic low_power_track_select,
	input wire logic burst_mode_enable,
	input wire logic ext_trigger_select,
	input wire logic sw_start,
	input wire logic external_convert_start,
	input wire logic low_power_state,
	input wire logic track_shutdown_enable,
	// converter core
	input wire logic sar_tick,
	input wire logic conv_done,
	input wire logic [RESULT_BITS-1:0] core_result,
	input wire logic track_en,
	input wire logic convert_active,
	input wire logic [RESULT_BITS-1:0] result,
	input wire logic result_valid,
	// reference controls
	input wire logic ground_ref_select,
	input wire atrc_vref_t voltage_ref_select,
	input wire logic temp_sensor_enable,
	input wire logic precision_ref_output_enable
);
	wire logic lp = low_power_track_select;
	wire logic ext = ext_trigger_select;
	wire logic shut = low_power_state && track_shutdown_enable;
	logic [7:0] n;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	function automatic logic [4:0] vdec(input logic [7:0] v);
		return {v[5], (v[4:3] == 2'b01) ? 2'b00 : v[4:3], v[2], v[0]};
	endfunction
	// ----------------
	// ticks seen while tracking
	// ----------------
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			n <= 8'h00;
		else
			n <= track_en ? n + {7'h00, sar_tick} : 8'h00;
	end
	a_conv_result: assert property (convert_active && conv_done |=> result_valid && !convert_active &&
		result == $past(core_result)) else $error("bad result");
	a_cont_track: assert property (!lp && !burst_mode_enable && !shut |=> track_en == !convert_active)
		else $error("bad tracking");
	a_shut_idle: assert property (shut && !lp && !sw_start |=> !track_en) else $error("no shutdown");
	a_lp_start: assert property (lp && !ext && sw_start && !track_en && !convert_active |=> track_en &&
		!convert_active) else $error("no lp track");
	a_lp_ticks: assert property ($rose(convert_active) && lp && !ext |-> n == 8'h03)
		else $error("bad tick count");
	a_pin_track: assert property (lp && ext && !convert_active |=> track_en == !$past(external_convert_start))
		else $error("bad pin tracking");
	a_pin_start: assert property (ext && $rose(external_convert_start) && !convert_active |=> convert_active)
		else $error("pin start missed");
	a_ref_write: assert property (sfr_wr && sfr_addr == 8'hD1 ##1 !sfr_wr |=>
		{ground_ref_select, voltage_ref_select, temp_sensor_enable, precision_ref_output_enable} ==
		vdec($past(sfr_wdata, 2))) else $error("bad ref outputs");
	a_read_mask: assert property (sfr_rd && sfr_addr == 8'hD1 |=> sfr_rdata[7:6] == 2'b00 && !sfr_rdata[1])
		else $error("unused bits set");
	c_lp_conv: cover property ($rose(convert_active) && lp && !ext);
	c_pin_conv: cover property ($rose(convert_active) && ext);
	c_ref_write: cover property (sfr_wr && sfr_addr == 8'hD1);
endmodule
`default_nettype wire

// ===== testbench/atrc_top_tb.sv
`default_nettype none
module atrc_top_tb
	import atrc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0, reset = 1'b1, ce = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, sw_start = 1'b0;
	logic low_power_track_select = 1'b0, burst_mode_enable = 1'b0, ext_trigger_select = 1'b0;
	logic external_convert_start = 1'b0, low_power_state = 1'b0, track_shutdown_enable = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
	logic [1:0] div = 2'h0;
	logic sar_tick, conv_done, track_en, convert_active, result_valid;
	logic ground_ref_select, temp_sensor_enable, precision_ref_output_enable;
	atrc_vref_t voltage_ref_select;
	logic [9:0] core_result, result, nconv = 10'h000;
	wire logic [4:0] refs = {ground_ref_select, voltage_ref_select, temp_sensor_enable, precision_ref_output_enable};
	int errors = 0, checks_done = 0;
	logic [7:0] vals [5] = '{8'hFF, 8'h00, 8'h0A, 8'hF2, 8'h2C};
	always #4 ref_clk = ~ref_clk;
	atrc_top i_atrc_top (.*);
	atrc_core_model i_atrc_core_model (.*);
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		{sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
		@(negedge ref_clk);
		sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge ref_clk);
		{sfr_addr, sfr_rd} = {a, 1'b1};
		@(negedge ref_clk);
		sfr_rd = 1'b0;
		chk(sfr_rdata, e);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// pin pulse or software start, then bounded wait for the result
	task automatic conv(input logic by_pin);
		int k;
		@(negedge ref_clk);
		if (by_pin)
			external_convert_start = 1'b1;
		else
			sw_start = 1'b1;
		@(negedge ref_clk);
		sw_start = 1'b0;
		external_convert_start = 1'b0;
		for (k = 0; k < 200 && result_valid !== 1'b1; k++)
			@(negedge ref_clk);
		nconv++;
		if (k < 200)
			chk(result, 10'h2AA + nconv - 10'h001);
		else begin
			errors++;
			end_of_test();
		end
	endtask
	initial begin
		int i;
		logic [7:0] v;
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'b0;
		rd(8'hD1, 8'h18);
		chk(refs, 5'h0C);
		rd(8'hD0, 8'h00);
		for (i = 0; i < 5; i++) begin
			v = vals[i];
			wr(8'hD1, v);
			rd(8'hD1, v & 8'h3D);
			chk(refs, {v[5], (v[4:3] == 2'b01) ? 2'b00 : v[4:3], v[2], v[0]});
		end
		wr(8'hD0, 8'hFF);
		rd(8'hD1, 8'h2C);
		$display("test registers done");
		chk(track_en, 1'b1);
		conv(1'b0);
		chk(track_en, 1'b1);
		burst_mode_enable = 1'b1;
		@(negedge ref_clk);
		chk(track_en, 1'b0);
		burst_mode_enable = 1'b0;
		{low_power_state, track_shutdown_enable} = 2'b11;
		@(negedge ref_clk);
		chk(track_en, 1'b0);
		{low_power_state, track_shutdown_enable} = 2'b00;
		@(negedge ref_clk);
		chk(track_en, 1'b1);
		// enable low: tracking level must stay frozen
		ce = 1'b0;
		burst_mode_enable = 1'b1;
		@(negedge ref_clk);
		chk(track_en, 1'b1);
		ce = 1'b1;
		burst_mode_enable = 1'b0;
		@(negedge ref_clk);
		$display("test continuous done");
		low_power_track_select = 1'b1;
		div = 2'h2;
		@(negedge ref_clk);
		chk(track_en, 1'b0);
		conv(1'b0);
		ext_trigger_select = 1'b1;
		@(negedge ref_clk);
		@(negedge ref_clk);
		chk(track_en, 1'b1);
		conv(1'b1);
		@(negedge ref_clk);
		chk(track_en, 1'b1);
		$display("test low power done");
		end_of_test();
	end
endmodule
bind atrc_top atrc_monitor #(.RESULT_BITS(RESULT_BITS)) i_atrc_monitor (.*);
`default_nettype wire
